// ===== hdl/csc_clock_ctrl.sv
// Clock source selection, CPU clock division and clock output.
// Assumes the oscillator option and classic timing come from
// non-volatile configuration, and that pin levels arrive unsynced.
`timescale 1ns/10ps
module csc_clock_ctrl (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Non-volatile configuration
  input wire csc_pkg::csc_osc_t cfg_osc_i,
  input wire logic cfg_classic_i,
  // Power control from the core
  input wire logic power_down_i,
  input wire logic idle_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Port 2 logic for the shared bits
  input wire logic port_p20_dout_i,
  input wire logic port_p20_den_i,
  input wire logic port_p21_dout_i,
  input wire logic port_p21_den_i,
  output logic port_p20_din_o,
  output logic port_p21_din_o,
  // Oscillator pins
  input wire logic osc_out_port_pin_i,
  output logic osc_out_port_pin_o,
  output logic osc_out_port_pin_oe_o,
  input wire logic osc_in_port_pin_i,
  output logic osc_in_port_pin_o,
  output logic osc_in_port_pin_oe_o,
  // CPU clock and wake status
  output logic cpu_tick_o,
  output logic cpu_run_o
);
  import csc_pkg::*;

  // ==========================================================
  // State
  typedef struct packed {
    logic cfg_done;
    csc_osc_t osc_mode;
    logic classic;
    logic [7:0] port2_mode_reg1;
    logic [7:0] cpu_clock_divider;
    csc_pwr_t pwr;
    logic [10:0] warm_cnt;
    logic [1:0] s1;
    logic [1:0] s2;
    logic [1:0] s3;
    logic [1:0] lvl;
    logic [15:0] rc_acc;
    logic osc_tick;
    logic [10:0] div_cnt;
    logic cpu_tick;
    logic [1:0] ck_cnt;
    logic ck_lvl;
    logic ckout_drv;
    logic out_o;
    logic out_oe;
    logic in_o;
    logic in_oe;
    logic p20_din;
    logic p21_din;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic run;
  } csc_state_t;

  csc_state_t st_r;
  csc_state_t st_nxt;

  // Crystal options take both pins for the amplifier
  function automatic logic is_xtal(input csc_osc_t m);
    is_xtal = (m == CSC_OSC_LF) || (m == CSC_OSC_MF) || (m == CSC_OSC_HF);
  endfunction : is_xtal

  // CPU period in oscillator clocks; 11 bits so 512 doubled fits
  function automatic logic [10:0] cpu_period(input logic [7:0] n,
                                             input logic cl);
    logic [10:0] p;
    p = (n == 8'h00) ? {1'b0, DIV_BASE} : {2'b00, n, 1'b0} + 11'h002;
    cpu_period = cl ? {p[9:0], 1'b0} : p;
  endfunction : cpu_period

  logic apb_acc;
  logic [15:0] rc_sum;
  logic ext_rise;
  logic [10:0] period;
  logic ckout_ok;
  assign apb_acc = psel_i && penable_i;
  assign rc_sum = st_r.rc_acc + RC_STEP;
  assign ext_rise = (st_r.s2[0] == st_r.s3[0]) && st_r.s3[0] && !st_r.lvl[0];
  assign period = cpu_period(st_r.cpu_clock_divider, st_r.classic);
  assign ckout_ok = (st_r.osc_mode == CSC_OSC_RC) ||
                    (st_r.osc_mode == CSC_OSC_EXT);

  // ==========================================================
  // Next-state logic
  always_comb begin
    st_nxt = st_r;
    // Configuration latched once, after reset release
    if (!st_r.cfg_done) begin
      st_nxt.cfg_done = 1'b1;
      st_nxt.osc_mode = cfg_osc_i;
      st_nxt.classic = cfg_classic_i;
    end
    // Pin synchronisers; bit 0 osc input, bit 1 osc output pin
    st_nxt.s1 = {osc_out_port_pin_i, osc_in_port_pin_i};
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    for (int i = 0; i < 2; i++) begin
      if (st_r.s2[i] == st_r.s3[i]) begin
        st_nxt.lvl[i] = st_r.s3[i];
      end
    end
    // Oscillator tick: RC from a rate accumulator, else from input pin
    st_nxt.osc_tick = 1'b0;
    if (st_r.pwr == CSC_STOPPED) begin
      st_nxt.rc_acc = 16'h0000;
    end else if (st_r.osc_mode == CSC_OSC_RC) begin
      if (rc_sum >= RC_WRAP) begin
        st_nxt.rc_acc = rc_sum - RC_WRAP;
        st_nxt.osc_tick = 1'b1;
      end else begin
        st_nxt.rc_acc = rc_sum;
      end
    end else begin
      // No edge, no tick: a stopped source simply halts the CPU
      st_nxt.osc_tick = ext_rise;
    end
    // Power down and oscillator warm-up
    st_nxt.cpu_tick = 1'b0;
    unique case (st_r.pwr)
      CSC_RUN: begin
        if (power_down_i) begin
          st_nxt.pwr = CSC_STOPPED;
        end else if (st_r.osc_tick) begin
          if (st_r.div_cnt >= period - 11'h001) begin
            st_nxt.div_cnt = 11'h000;
            st_nxt.cpu_tick = 1'b1;
          end else begin
            st_nxt.div_cnt = st_r.div_cnt + 11'h001;
          end
        end
      end
      CSC_STOPPED: begin
        if (!power_down_i) begin
          st_nxt.pwr = CSC_WARMUP;
          st_nxt.warm_cnt = 11'h000;
        end
      end
      CSC_WARMUP: begin
        if (st_r.osc_tick) begin
          st_nxt.warm_cnt = st_r.warm_cnt + 11'h001;
          if (st_r.warm_cnt + 11'h001 ==
              (is_xtal(st_r.osc_mode) ? WARM_XTAL : WARM_RC_EXT)) begin
            st_nxt.pwr = CSC_RUN;
            st_nxt.div_cnt = 11'h000;
          end
        end
      end
    endcase
    // Run status kept in its own flop so the output is registered
    st_nxt.run = (st_nxt.pwr == CSC_RUN);
    // Clock output: toggles every third CPU tick; Idle does not gate it
    st_nxt.ckout_drv = st_r.cfg_done && ckout_ok &&
                       st_r.port2_mode_reg1[CKOUT_EN_BIT] &&
                       (st_r.pwr != CSC_STOPPED);
    if (!st_nxt.ckout_drv) begin
      st_nxt.ck_cnt = 2'h0;
      st_nxt.ck_lvl = 1'b0;
    end else if (st_r.cpu_tick) begin
      if (st_r.ck_cnt == CKOUT_HALF) begin
        st_nxt.ck_cnt = 2'h0;
        st_nxt.ck_lvl = !st_r.ck_lvl;
      end else begin
        st_nxt.ck_cnt = st_r.ck_cnt + 2'h1;
      end
    end
    // Pin muxing between oscillator and port 2 functions
    if (!st_r.cfg_done || is_xtal(st_r.osc_mode)) begin
      st_nxt.out_o = 1'b0;
      st_nxt.out_oe = 1'b0;
      st_nxt.in_o = 1'b0;
      st_nxt.in_oe = 1'b0;
      st_nxt.p20_din = 1'b0;
      st_nxt.p21_din = 1'b0;
    end else begin
      st_nxt.out_o = st_nxt.ckout_drv ? st_nxt.ck_lvl : port_p20_dout_i;
      st_nxt.out_oe = st_nxt.ckout_drv || port_p20_den_i;
      st_nxt.p20_din = st_r.lvl[1];
      // In external mode the input pin carries the clock
      st_nxt.in_o = (st_r.osc_mode == CSC_OSC_RC) && port_p21_dout_i;
      st_nxt.in_oe = (st_r.osc_mode == CSC_OSC_RC) && port_p21_den_i;
      st_nxt.p21_din = (st_r.osc_mode == CSC_OSC_RC) && st_r.lvl[0];
    end
    // APB: one wait state, answer on the second access cycle
    st_nxt.pready = apb_acc && !st_r.pready;
    st_nxt.pslverr = 1'b0;
    st_nxt.prdata = 32'h0000_0000;
    if (apb_acc && !st_r.pready) begin
      unique case (paddr_i)
        ADDR_PORT2_MODE_REG1: st_nxt.prdata[7:0] = st_r.port2_mode_reg1;
        ADDR_CPU_CLOCK_DIVIDER: st_nxt.prdata[7:0] = st_r.cpu_clock_divider;
        ADDR_STAT: begin
          st_nxt.prdata[ST_MODE_LSB +: 3] = st_r.osc_mode;
          st_nxt.prdata[ST_CLASSIC_BIT] = st_r.classic;
          st_nxt.prdata[ST_RUN_BIT] = st_r.pwr == CSC_RUN;
          st_nxt.prdata[ST_WARM_BIT] = st_r.pwr == CSC_WARMUP;
          st_nxt.prdata[ST_CKOUT_BIT] = st_r.ckout_drv;
        end
        default: st_nxt.pslverr = 1'b1;
      endcase
      if (pwrite_i && (paddr_i == ADDR_STAT)) begin
        st_nxt.pslverr = 1'b1;
      end
    end
    // Writes land on the edge that completes the transfer
    if (apb_acc && st_r.pready && pwrite_i) begin
      if (paddr_i == ADDR_PORT2_MODE_REG1) begin
        st_nxt.port2_mode_reg1 = pwdata_i[7:0];
      end
      if (paddr_i == ADDR_CPU_CLOCK_DIVIDER) begin
        st_nxt.cpu_clock_divider = pwdata_i[7:0];
      end
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      st_r <= '0;
      st_r.osc_mode <= CSC_OSC_LF;
      st_r.pwr <= CSC_RUN;
      st_r.run <= 1'b1;
      st_r.port2_mode_reg1 <= PORT2_MODE_REG1_RST;
      st_r.cpu_clock_divider <= CPU_CLOCK_DIVIDER_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state flops
  assign prdata_o = st_r.prdata;
  assign pready_o = st_r.pready;
  assign pslverr_o = st_r.pslverr;
  assign port_p20_din_o = st_r.p20_din;
  assign port_p21_din_o = st_r.p21_din;
  assign osc_out_port_pin_o = st_r.out_o;
  assign osc_out_port_pin_oe_o = st_r.out_oe;
  assign osc_in_port_pin_o = st_r.in_o;
  assign osc_in_port_pin_oe_o = st_r.in_oe;
  assign cpu_tick_o = st_r.cpu_tick;
  assign cpu_run_o = st_r.run;

  // ==========================================================
  // Assertions
  a_cfg_frozen: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $past(st_r.cfg_done) |-> $stable(st_r.osc_mode))
    else $error("oscillator option changed at run time");
  a_rc_rate: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    st_r.osc_tick && st_r.osc_mode == CSC_OSC_RC |=> !st_r.osc_tick [*5])
    else $error("RC tick faster than 6 MHz");
  a_clkout_gate: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    st_r.ckout_drv |-> ckout_ok && $past(st_r.port2_mode_reg1[CKOUT_EN_BIT]))
    else $error("clock output without enable or allowed mode");
  a_clkout_sixth: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    st_r.ckout_drv && st_r.cpu_tick && st_r.ck_cnt != CKOUT_HALF
    ##1 st_r.ckout_drv |-> $stable(st_r.ck_lvl))
    else $error("clock output toggled early");
  a_xtal_pins: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    st_r.cfg_done && is_xtal(st_r.osc_mode) |=>
    !osc_out_port_pin_oe_o && !osc_in_port_pin_oe_o && !port_p20_din_o)
    else $error("port function on crystal pins");
  a_div_spacing: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    st_r.cpu_tick && st_r.cpu_clock_divider != 8'h00 |=> !st_r.cpu_tick [*3])
    else $error("CPU clock divided by less than four");
  a_classic_half: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    st_r.cpu_tick && st_r.classic |=> !st_r.cpu_tick)
    else $error("classic timing not halved");
  a_wake_wait: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    st_r.pwr == CSC_STOPPED && !power_down_i |=>
    st_r.pwr == CSC_WARMUP && st_r.warm_cnt == 11'h000 ##1 !cpu_tick_o)
    else $error("wake without oscillator warm-up");
  a_port_release: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    st_r.cfg_done && st_r.osc_mode == CSC_OSC_EXT && !st_nxt.ckout_drv |=>
    osc_out_port_pin_oe_o == $past(port_p20_den_i))
    else $error("output pin not returned to port");
  a_stop_quiet: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    st_r.pwr == CSC_STOPPED |=> !st_r.ckout_drv && !st_r.ck_lvl)
    else $error("clock output in power down");
  a_idle_clkout: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    idle_i && st_r.cfg_done && ckout_ok && st_r.port2_mode_reg1[CKOUT_EN_BIT] &&
    st_r.pwr != CSC_STOPPED |=> st_r.ckout_drv)
    else $error("clock output stopped in idle");
endmodule : csc_clock_ctrl

// ===== hdl/csc_pkg.sv
// Constants for the clock source and clock output block.
// Assumes a 40 MHz system clock and a 32-bit APB master.
package csc_pkg;
  // ==========================================================
  // Clock and oscillator rates
  localparam int CLK_KHZ = 40000;
  localparam int RC_KHZ = 6000;
  localparam logic [15:0] RC_STEP = RC_KHZ[15:0];
  localparam logic [15:0] RC_WRAP = CLK_KHZ[15:0];
  // ==========================================================
  // Wake-up stability counts, in oscillator clocks
  localparam logic [10:0] WARM_XTAL = 11'h400;
  localparam logic [10:0] WARM_RC_EXT = 11'h100;
  // ==========================================================
  // Divider and clock output figures
  localparam logic [9:0] DIV_BASE = 10'h001;
  localparam logic [1:0] CKOUT_HALF = 2'h2;
  // ==========================================================
  // APB register byte offsets
  localparam logic [7:0] ADDR_PORT2_MODE_REG1 = 8'h00;
  localparam logic [7:0] ADDR_CPU_CLOCK_DIVIDER = 8'h04;
  localparam logic [7:0] ADDR_STAT = 8'h08;
  // ==========================================================
  // Field positions
  localparam int CKOUT_EN_BIT = 6;
  localparam int ST_MODE_LSB = 0;
  localparam int ST_CLASSIC_BIT = 3;
  localparam int ST_RUN_BIT = 4;
  localparam int ST_WARM_BIT = 5;
  localparam int ST_CKOUT_BIT = 6;
  localparam logic [7:0] PORT2_MODE_REG1_RST = 8'h00;
  localparam logic [7:0] CPU_CLOCK_DIVIDER_RST = 8'h00;
  // ==========================================================
  // Oscillator options, fixed at programming time
  typedef enum logic [2:0] {
    CSC_OSC_LF = 3'h0,
    CSC_OSC_MF = 3'h1,
    CSC_OSC_HF = 3'h2,
    CSC_OSC_RC = 3'h3,
    CSC_OSC_EXT = 3'h4
  } csc_osc_t;
  typedef enum logic [1:0] {
    CSC_RUN,
    CSC_STOPPED,
    CSC_WARMUP
  } csc_pwr_t;
endpackage : csc_pkg

// ===== sim/csc_osc_src.sv
// External clock source that feeds the oscillator input pin.
// Assumes the bench clock; one source period is 2*HALF bench cycles.
`timescale 1ns/10ps
module csc_osc_src #(
  parameter int HALF = 2
) (
  // Bench clock and run control
  input wire logic clk_i,
  input wire logic run_i,
  // Clock toward the oscillator input pin
  output logic osc_o
);
  int cnt;
  // ==========================================================
  // Source clock
  initial begin
    osc_o = 1'b0;
    cnt = 0;
  end
  // A stopped source holds its level, so a 0 Hz input is exercised
  always @(posedge clk_i) begin
    if (run_i) begin
      if (cnt == HALF - 1) begin
        cnt <= 0;
        osc_o <= ~osc_o;
      end else begin
        cnt <= cnt + 1;
      end
    end
  end
endmodule : csc_osc_src

// ===== sim/csc_clock_ctrl_tb.sv
// Self-checking bench for the clock source and clock output block.
// Assumes a 40 MHz clock, APB access and an external source model.
`timescale 1ns/10ps
module csc_clock_ctrl_tb;
  import csc_pkg::*;
  logic clk_i, sys_rst, pd, idle, psel, pen, pwr, run_osc, cls, er;
  logic d20, e20, d21, e21;
  logic [7:0] paddr;
  logic [31:0] pwdata, rd;
  csc_osc_t cfg;
  wire logic [31:0] prdata;
  wire logic pready, pslverr, din20, din21, o20, oe20, o21, oe21;
  wire logic tick, run, src;
  int n_mismatch, total_checks, cyc, g;
  // Undriven output pin floats high through its pull-up
  wire logic pin20 = oe20 ? o20 : 1'b1;
  wire logic pin21 = oe21 ? o21 : src;
  // ==========================================================
  // Instances
  csc_clock_ctrl i_csc_clock_ctrl (.clk_i(clk_i), .sys_rst_i(sys_rst),
    .cfg_osc_i(cfg), .cfg_classic_i(cls), .power_down_i(pd),
    .idle_i(idle), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .port_p20_dout_i(d20),
    .port_p20_den_i(e20), .port_p21_dout_i(d21), .port_p21_den_i(e21),
    .port_p20_din_o(din20), .port_p21_din_o(din21),
    .osc_out_port_pin_i(pin20), .osc_out_port_pin_o(o20),
    .osc_out_port_pin_oe_o(oe20), .osc_in_port_pin_i(pin21),
    .osc_in_port_pin_o(o21), .osc_in_port_pin_oe_o(oe21),
    .cpu_tick_o(tick), .cpu_run_o(run));
  csc_osc_src #(.HALF(2)) i_csc_osc_src (.clk_i(clk_i), .run_i(run_osc),
    .osc_o(src));
  // ==========================================================
  // Clock and hang guard
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  // Whole run needs about 14000 cycles
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      summarize();
    end
  end
  // ==========================================================
  // Tasks
  task summarize();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize
  task check(input logic [31:0] s, input logic [31:0] e, input string m);
    total_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("wrong value t=%0t %s: %h vs %h", $time, m, s, e);
    end
  endtask : check
  // One APB transfer; holds everything until pready is sampled
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    pen <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) n_mismatch++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task restart(input csc_osc_t m, input logic c);
    @(posedge clk_i);
    sys_rst <= 1'b1;
    cfg <= m;
    cls <= c;
    repeat (5) @(posedge clk_i);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask : restart
  // Cycles from one CPU tick to the next
  task gap(output int n);
    n = 0;
    do @(posedge clk_i); while (tick !== 1'b1 && ++n < 5000);
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (tick !== 1'b1 && n < 5000);
  endtask : gap
  // CPU ticks between two clock output edges
  task ckgap(output int k);
    logic p;
    int n;
    k = 0;
    n = 0;
    @(posedge clk_i);
    p = o20;
    while (o20 === p && n < 500) begin
      @(posedge clk_i);
      n++;
    end
    p = o20;
    while (o20 === p && n < 500) begin
      k += int'(tick);
      @(posedge clk_i);
      n++;
    end
  endtask : ckgap
  task wake(output int n);
    pd <= 1'b1;
    repeat (20) @(posedge clk_i);
    check(run, 0, "run in power down");
    check(oe20, 0, "pin in power down");
    pd <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (run !== 1'b1 && n < 6000);
  endtask : wake
  // ==========================================================
  // Tests
  initial begin
    {pd, idle, psel, pen, pwr, cls, d20, e20, d21, e21} = '0;
    {sys_rst, run_osc} = 2'b11;
    paddr = 8'h00;
    pwdata = 32'h0;
    cfg = CSC_OSC_RC;
    {n_mismatch, total_checks, cyc} = '0;
    for (int m = 0; m < 5; m++) begin
      restart(csc_osc_t'(m), 1'b0);
      apb(1'b0, ADDR_STAT, 32'h0);
      check(rd[2:0], m[2:0], "mode");
      apb(1'b1, ADDR_PORT2_MODE_REG1, 32'h40);
      repeat (4) @(posedge clk_i);
      check(oe20, (m == 3 || m == 4), "clock out per mode");
    end
    $display("test modes done");
    restart(CSC_OSC_RC, 1'b0);
    apb(1'b0, ADDR_PORT2_MODE_REG1, 32'h0);
    check(rd, {24'h0, PORT2_MODE_REG1_RST}, "port2_mode_reg1 reset");
    apb(1'b0, ADDR_CPU_CLOCK_DIVIDER, 32'h0);
    check(rd, {24'h0, CPU_CLOCK_DIVIDER_RST}, "cpu_clock_divider reset");
    apb(1'b0, 8'h0C, 32'h0);
    check(er, 1, "unmapped");
    apb(1'b1, ADDR_STAT, 32'hFF);
    check(er, 1, "status write");
    gap(g);
    check(g >= 6 && g <= 7, 1, "rc tick");
    check(oe20, 0, "disabled pin");
    apb(1'b1, ADDR_PORT2_MODE_REG1, 32'h40);
    repeat (4) @(posedge clk_i);
    check(oe20, 1, "enabled pin");
    ckgap(g);
    check(g, 3, "divide by six");
    idle <= 1'b1;
    ckgap(g);
    check(g, 3, "idle clock out");
    apb(1'b1, ADDR_PORT2_MODE_REG1, 32'h0);
    repeat (4) @(posedge clk_i);
    check(oe20, 0, "cleared pin");
    idle <= 1'b0;
    $display("test rc done");
    restart(CSC_OSC_EXT, 1'b0);
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, ADDR_CPU_CLOCK_DIVIDER, (i == 0) ? 32'h0 : (i == 1) ? 32'h1 : 32'hFF);
      gap(g);
      gap(g);
      check(g, (i == 0) ? 4 : (i == 1) ? 16 : 2048, "ext div");
    end
    apb(1'b1, ADDR_CPU_CLOCK_DIVIDER, 32'h0);
    {e20, d20, e21, d21} <= 4'hF;
    repeat (8) @(posedge clk_i);
    check({oe20, o20, din20, oe21}, 4'hE, "ext port bit");
    d20 <= 1'b0;
    repeat (8) @(posedge clk_i);
    check(din20, 0, "ext port low");
    {e20, e21} <= 2'b00;
    apb(1'b1, ADDR_PORT2_MODE_REG1, 32'h40);
    ckgap(g);
    check(g, 3, "ext divide by six");
    run_osc <= 1'b0;
    // Let an edge already in the synchroniser drain first
    repeat (8) @(posedge clk_i);
    g = 0;
    repeat (100) @(posedge clk_i) g += int'(tick);
    check(g, 0, "stopped source");
    run_osc <= 1'b1;
    gap(g);
    gap(g);
    check(g, 4, "restarted source");
    wake(g);
    check(g >= 1020 && g <= 1032, 1, "ext wake");
    $display("test ext done");
    restart(CSC_OSC_EXT, 1'b1);
    gap(g);
    gap(g);
    check(g, 8, "classic");
    apb(1'b1, ADDR_CPU_CLOCK_DIVIDER, 32'h1);
    gap(g);
    gap(g);
    check(g, 32, "classic div");
    $display("test classic done");
    restart(CSC_OSC_LF, 1'b0);
    {e20, d20, e21, d21} <= 4'hF;
    repeat (8) @(posedge clk_i);
    check({oe20, oe21, din20, din21}, 4'h0, "crystal pins");
    {e20, e21} <= 2'b00;
    wake(g);
    check(g >= 4092 && g <= 4104, 1, "crystal wake");
    $display("test crystal done");
    summarize();
  end
endmodule : csc_clock_ctrl_tb
